// ==== design/trigger_bus_crosspoint_pkg.sv ====
// package: register map, pattern layout and pin assignments of the crosspoint
package trigger_bus_crosspoint_pkg;
    localparam int PIN_COUNT = 7;
    localparam int FIELD_WIDTH = 4;
    localparam int HALF_WIDTH = 28;
    localparam int PATTERN_WIDTH = 56;
    localparam int SEL_LSB = 1;
    localparam int SEL_WIDTH = 3;
    localparam int OE_BIT = 0;
    // byte addresses on apb
    localparam logic [7:0] ADDR_SHIFT = 8'h00;
    localparam logic [7:0] ADDR_STROBE = 8'h04;
    localparam logic [7:0] ADDR_LOCAL_CTRL = 8'h08;
    localparam logic [7:0] ADDR_ACTIVE_LO = 8'h0c;
    localparam logic [7:0] ADDR_ACTIVE_HI = 8'h10;
    localparam logic [7:0] ADDR_STAGED_LO = 8'h14;
    localparam logic [7:0] ADDR_STAGED_HI = 8'h18;
    // local control field positions
    localparam int CTRL_PIN2_DRIVE = 0;
    localparam int CTRL_PIN2_RECEIVE = 1;
    localparam int CTRL_PIN4_DRIVE = 2;
    localparam int CTRL_PIN4_RECEIVE = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [55:0] PATTERN_RESET = 56'h00000000000000;
    // board-side pin indexes
    localparam int PIN_EXT_CONVERT = 0;
    localparam int PIN_FREQ_OUT = 1;
    localparam int PIN_CNT2_COUNTER1_GATE_INPUT = 2;
    localparam int PIN_CNT5_SOURCE = 3;
    localparam int PIN_CNT5_DACUP = 4;
    localparam int PIN_CNT1_OUT = 5;
    localparam int PIN_EXT_TRIGGER = 6;

    // one pin group: seven values in, values out, output enables (low = driving)
    typedef struct packed {
        logic [6:0] in;
        logic [6:0] out;
        logic [6:0] oeN;
    } pin_group_t;
endpackage : trigger_bus_crosspoint_pkg

// ==== design/trigger_bus_crosspoint_switch.sv ====
// module: trigger bus crosspoint switch with apb register access
//
// Behaviour
// (R1) seven board-side pins and seven bus-side pins, indexed six to zero
// (R2) board pins carry convert, frequency, counter and trigger signals
// (R3) pin2 drive select lets counter2 output drive board pin 2
// (R4) pin2 receive select feeds counter1 gate from board pin 2
// (R5) both pin2 selects set: counter1 gate gets counter2 output directly
// (R6) pin4 drive select lets counter5 output drive board pin 4
// (R7) pin4 receive select routes board pin 4 onto dac update trigger
// (R8) both pin4 selects set: dac update trigger driven by counter5 output
// (R9) routing loads as 56 serial bits, then a strobe commits it
// (R10) low 28 bits control bus pins, high 28 bits control board pins
// (R11) each half holds seven 4-bit fields, selector plus output enable
// (R12) selector value picks opposite-side pin of the same index
// (R13) selector in upper three bits, output enable in lowest bit
// (R14) enable set drives pin from source; clear leaves pin undriven
// (R15) software disables unused and input pins, enables outputs
// (R16) software shifts pattern bit 0 first, value in bit 0 of data
// (R17) shift register captures only bit 0 of each write
// (R18) strobe write loads shifted pattern; routing changes at once (here the pin outputs follow one cycle after active_reg loads)
// (R19) active routing unchanged while bits are shifted in
// (R20) each shift moves pattern toward bit 0
`timescale 1ns/10ps
module trigger_bus_crosspoint_switch
    import trigger_bus_crosspoint_pkg::*;
(
    input wire logic mclk, // system clock, 100 MHz
    input wire logic reset, // asynchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high = write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [6:0] boardIn, // board pin levels seen at the switch
    output logic [6:0] boardOut, // board pin values driven by the switch
    output logic [6:0] boardOeN, // board pin enables, low = switch drives
    input wire logic [6:0] busIn, // trigger line levels
    output logic [6:0] busOut, // trigger line values driven
    output logic [6:0] busOeN, // trigger line enables, low = drives
    input wire logic counter2_output, // counter 2 output
    input wire logic counter5_output, // counter 5 output
    output logic counter1_gate_input, // counter 1 gate
    output logic dac_update_trigger_n, // dac update trigger, active low
    output logic cnt2DriveN, // counter2 drive enable on pin 2, low = on
    output logic cnt5DriveN // counter5 drive enable on pin 4, low = on
);

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic access;
    logic wrAccess;
    logic mapped;
    logic [55:0] staged_reg;
    logic [55:0] active_reg;
    logic [3:0] localCtrl_reg;
    logic pin2_drive_select;
    logic pin2_receive_select;
    logic pin4_drive_select;
    logic pin4_receive_select;

    // zero wait states: every access completes in its first access cycle
    assign access = psel && penable;
    assign wrAccess = access && pwrite && mapped;
    assign pready = access;
    assign pslverr = access && !mapped;

    // address decode of the seven words
    always_comb begin
        unique case (paddr)
            ADDR_SHIFT, ADDR_STROBE, ADDR_LOCAL_CTRL,
            ADDR_ACTIVE_LO, ADDR_ACTIVE_HI,
            ADDR_STAGED_LO, ADDR_STAGED_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // serial pattern load and commit
    // ------------------------------------------------------------

    // shift one bit in at the top, older bits move toward bit 0
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            staged_reg <= PATTERN_RESET;
        end else if (wrAccess && paddr == ADDR_SHIFT) begin
            staged_reg <= {pwdata[0], staged_reg[55:1]}; // [R9] [R17] [R20]
        end
    end

    // strobe copies the staged pattern; any write value commits
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            active_reg <= PATTERN_RESET;
        end else if (wrAccess && paddr == ADDR_STROBE) begin
            active_reg <= staged_reg; // [R9] [R18] [R19]
        end
    end

    // local select bits for the shared board pins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            localCtrl_reg <= CTRL_RESET;
        end else if (wrAccess && paddr == ADDR_LOCAL_CTRL) begin
            localCtrl_reg <= pwdata[3:0];
        end
    end

    assign pin2_drive_select = localCtrl_reg[CTRL_PIN2_DRIVE];
    assign pin2_receive_select = localCtrl_reg[CTRL_PIN2_RECEIVE];
    assign pin4_drive_select = localCtrl_reg[CTRL_PIN4_DRIVE];
    assign pin4_receive_select = localCtrl_reg[CTRL_PIN4_RECEIVE];

    // read data register; write-only ports read as zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_LOCAL_CTRL: prdata <= {28'h0000000, localCtrl_reg};
                ADDR_ACTIVE_LO: prdata <= active_reg[31:0];
                ADDR_ACTIVE_HI: prdata <= {8'h00, active_reg[55:32]};
                ADDR_STAGED_LO: prdata <= staged_reg[31:0];
                ADDR_STAGED_HI: prdata <= {8'h00, staged_reg[55:32]};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // crosspoint matrix
    // ------------------------------------------------------------
    logic [27:0] busHalf;
    logic [27:0] boardHalf;
    logic [6:0] boardLevel;
    logic [6:0] busLevel;
    logic [6:0] boardNext;
    logic [6:0] boardOeNext;
    logic [6:0] busNext;
    logic [6:0] busOeNext;

    assign busHalf = active_reg[HALF_WIDTH-1:0]; // [R10]
    assign boardHalf = active_reg[PATTERN_WIDTH-1:HALF_WIDTH]; // [R10]

    // board pin 2 and 4 levels include the local counter drivers
    always_comb begin
        boardLevel = boardIn;
        if (pin2_drive_select) begin
            boardLevel[PIN_CNT2_COUNTER1_GATE_INPUT] = counter2_output; // [R3] [R2]
        end
        if (pin4_drive_select) begin
            boardLevel[PIN_CNT5_DACUP] = counter5_output; // [R6] [R2]
        end
    end
    assign busLevel = busIn;

    // each pin takes its field: selector picks opposite index
    always_comb begin
        logic [3:0] bField;
        logic [3:0] aField;
        logic [2:0] bSel;
        logic [2:0] aSel;
        bField = 4'h0;
        aField = 4'h0;
        bSel = 3'h0;
        aSel = 3'h0;
        boardNext = 7'h00;
        boardOeNext = 7'h7f;
        busNext = 7'h00;
        busOeNext = 7'h7f;
        for (int i = 0; i < PIN_COUNT; i++) begin
            bField = busHalf[i*FIELD_WIDTH +: FIELD_WIDTH]; // [R11]
            aField = boardHalf[i*FIELD_WIDTH +: FIELD_WIDTH]; // [R11]
            bSel = bField[SEL_LSB +: SEL_WIDTH]; // [R13]
            aSel = aField[SEL_LSB +: SEL_WIDTH]; // [R13]
            // index 7 has no pin and yields zero
            busNext[i] = (bSel < 3'h7) ? boardLevel[bSel] : 1'b0; // [R12]
            boardNext[i] = (aSel < 3'h7) ? busLevel[aSel] : 1'b0; // [R12]
            busOeNext[i] = !bField[OE_BIT]; // [R14]
            boardOeNext[i] = !aField[OE_BIT]; // [R14]
        end
    end

    // registered pin outputs, one cycle after the level changes
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            boardOut <= 7'h00;
            boardOeN <= 7'h7f;
            busOut <= 7'h00;
            busOeN <= 7'h7f;
        end else begin
            boardOut <= boardNext; // [R1] [R14]
            boardOeN <= boardOeNext;
            busOut <= busNext;
            busOeN <= busOeNext;
        end
    end

    // ------------------------------------------------------------
    // shared board pins 2 and 4
    // ------------------------------------------------------------
    logic [6:0] boardWire;

    // effective board pin level: switch drive wins over input
    assign boardWire = (boardOut & ~boardOeN) | (boardLevel & boardOeN);

    // counter gate and dac trigger taps, registered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            counter1_gate_input <= 1'b0;
            dac_update_trigger_n <= 1'b1;
            cnt2DriveN <= 1'b1;
            cnt5DriveN <= 1'b1;
        end else begin
            cnt2DriveN <= !pin2_drive_select; // [R3]
            cnt5DriveN <= !pin4_drive_select; // [R6]
            if (pin2_receive_select && pin2_drive_select) begin
                counter1_gate_input <= counter2_output; // [R5]
            end else if (pin2_receive_select) begin
                counter1_gate_input <= boardWire[PIN_CNT2_COUNTER1_GATE_INPUT]; // [R4]
            end else begin
                counter1_gate_input <= 1'b0; // [R4]
            end
            if (pin4_receive_select && pin4_drive_select) begin
                dac_update_trigger_n <= counter5_output; // [R8]
            end else if (pin4_receive_select) begin
                dac_update_trigger_n <= boardWire[PIN_CNT5_DACUP]; // [R7]
            end else begin
                dac_update_trigger_n <= 1'b1; // [R7]
            end
        end
    end

endmodule // trigger_bus_crosspoint_switch

// ==== testbench/tb_trigger_bus_crosspoint_switch.sv ====
// testbench: crosspoint routing, local selects and register port
`timescale 1ns/10ps
module tb_trigger_bus_crosspoint_switch;
    import trigger_bus_crosspoint_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, c2 = 1'b0, c5 = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, lfsr = 32'h10000, rd, prdata;
    logic pready, pslverr, gate, dacN, d2N, d5N;
    logic [6:0] bIn, bOut, bOeN, bVal = 7'h00, busIn, busOut, busOeN;
    logic [6:0] fVal = 7'h00, fEn = 7'h00, dir;
    logic [55:0] pat, old;
    int errTotal = 0, numChecks = 0, cyc = 0;
    trigger_bus_crosspoint_switch DUT (.mclk(mclk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boardIn(bIn), .boardOut(bOut),
        .boardOeN(bOeN), .busIn(busIn), .busOut(busOut), .busOeN(busOeN),
        .counter2_output(c2), .counter5_output(c5),
        .counter1_gate_input(gate), .dac_update_trigger_n(dacN),
        .cnt2DriveN(d2N), .cnt5DriveN(d5N));
    trigger_line_partner far (.mclk(mclk), .busOut(busOut),
        .busOeN(busOeN), .farVal(fVal), .farEn(fEn), .busIn(busIn));
    always #5 mclk = ~mclk;
    // board pin level: switch, counter drive or board signal
    always_comb begin
        bIn = (bOut & ~bOeN) | (bVal & bOeN);
        if (!d2N) bIn[2] = c2;
        if (!d5N) bIn[4] = c5;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [3:0] expLocal(input logic [3:0] k,
        input logic a, b, input logic [6:0] p);
        return {k[1] & (k[0] ? a : p[2]), !k[3] | (k[2] ? b : p[4]),
            !k[0], !k[2]};
    endfunction
    // routing with no loops: dir marks switch-driven trigger lines
    function automatic logic [55:0] mkPat(input logic [6:0] d);
        logic [55:0] p;
        logic [2:0] s;
        p = 56'h0;
        for (int i = 0; i < 14; i++) begin
            lfsr = nxt(lfsr);
            s = 3'h7;
            p[4*i+3 -: 3] = lfsr[7:5];
            for (int j = 0; j < 7; j++)
                if (d[j] == (i < 7) && (s == 3'h7 || lfsr[8+j])) s = 3'(j);
            if (s != 3'h7 && d[i%7] == (i < 7) && lfsr[4])
                p[4*i+3 -: 4] = {s, 1'b1};
        end
        return p;
    endfunction
    function automatic logic [27:0] expPins(input logic [55:0] p,
        input logic [6:0] b, f);
        logic [27:0] r;
        for (int i = 0; i < 7; i++) begin
            r[i] = p[4*i];
            r[7+i] = p[28+4*i];
            r[14+i] = p[4*i] & b[p[4*i+3 -: 3]];
            r[21+i] = p[28+4*i] & f[p[4*i+31 -: 3]];
        end
        return r;
    endfunction
    task automatic chk(input string n, input logic [55:0] e, g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk("pready", 56'h1, {55'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic give_verdict;
        if (errTotal == 0 && numChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errTotal++;
            give_verdict;
        end
    end
    // local selects, then one fixed and seven random routings, then an unmapped access
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, ADDR_LOCAL_CTRL, 32'(k));
            lfsr = nxt(lfsr);
            c2 <= lfsr[0];
            c5 <= lfsr[1];
            bVal <= lfsr[8:2];
            repeat (3) @(posedge mclk);
            #1;
            chk("local", expLocal(4'(k), c2, c5, bVal),
                {gate, dacN, d2N, d5N});
        end
        apb(1'b1, ADDR_LOCAL_CTRL, 32'h0);
        for (int t = 0; t < 8; t++) begin
            lfsr = nxt(lfsr);
            dir = t == 0 ? 7'h30 : lfsr[6:0];
            pat = t == 0 ? 56'h700b0000 : mkPat(dir);
            fEn <= ~dir;
            fVal <= lfsr[14:8];
            bVal <= lfsr[21:15];
            old = {bOeN, busOeN};
            for (int i = 0; i < 56; i++) begin
                lfsr = nxt(lfsr);
                apb(1'b1, ADDR_SHIFT, {lfsr[30:0], pat[i]});
            end
            apb(1'b0, ADDR_STAGED_LO, 32'h0);
            chk("staged lo", {24'h0, pat[31:0]}, {24'h0, rd});
            apb(1'b0, ADDR_STAGED_HI, 32'h0);
            chk("staged hi", {32'h0, pat[55:32]}, {24'h0, rd});
            #1;
            chk("held", old, {bOeN, busOeN});
            apb(1'b1, ADDR_STROBE, 32'h0);
            repeat (3) @(posedge mclk);
            #1;
            chk("pins", expPins(pat, bVal, fVal),
                {bOut & ~bOeN, busOut & ~busOeN, ~bOeN, ~busOeN});
        end
        apb(1'b0, ADDR_ACTIVE_HI, 32'h0);
        chk("active hi", {32'h0, pat[55:32]}, {24'h0, rd});
        reset <= 1'b1;
        @(posedge mclk);
        #1;
        chk("reset oe", 56'h3fff, {bOeN, busOeN});
        @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 56'h2, {err, |rd});
        give_verdict;
    end
endmodule // tb_trigger_bus_crosspoint_switch
bind trigger_bus_crosspoint_switch trigger_bus_crosspoint_checker checkInst (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .boardIn(boardIn),
    .boardOut(boardOut), .boardOeN(boardOeN), .busIn(busIn),
    .busOut(busOut), .busOeN(busOeN), .counter2_output(counter2_output),
    .counter5_output(counter5_output),
    .counter1_gate_input(counter1_gate_input),
    .dac_update_trigger_n(dac_update_trigger_n),
    .cnt2DriveN(cnt2DriveN), .cnt5DriveN(cnt5DriveN));

// ==== testbench/trigger_bus_crosspoint_checker.sv ====
// checker: routing and local select relations at the switch ports
`timescale 1ns/10ps
module trigger_bus_crosspoint_checker
    import trigger_bus_crosspoint_pkg::*;
(
    input wire logic mclk, reset, psel, penable, pwrite, // clock and bus
    input wire logic [7:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    input wire logic [6:0] boardIn, boardOut, boardOeN, // board pins
    input wire logic [6:0] busIn, busOut, busOeN, // trigger lines
    input wire logic counter2_output, counter5_output, // counters
    input wire logic counter1_gate_input, dac_update_trigger_n, // local
    input wire logic cnt2DriveN, cnt5DriveN // counter drive enables
);
    logic [3:0] ctl;
    logic [55:0] stg, act;
    logic [6:0] eff, xBus, xBrd, eBus, eBrd;
    wire wr = psel && penable && pwrite;
    // shadow registers, updated at each accepted write
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctl <= CTRL_RESET;
            stg <= PATTERN_RESET;
            act <= PATTERN_RESET;
        end else if (wr) begin
            if (paddr == ADDR_SHIFT) stg <= {pwdata[0], stg[55:1]};
            if (paddr == ADDR_STROBE) act <= stg;
            if (paddr == ADDR_LOCAL_CTRL) ctl <= pwdata[3:0];
        end
    end
    // expected pin values and enables from the active routing
    always_comb begin
        eff = boardIn;
        if (ctl[CTRL_PIN2_DRIVE]) eff[2] = counter2_output;
        if (ctl[CTRL_PIN4_DRIVE]) eff[4] = counter5_output;
        for (int i = 0; i < 7; i++) begin
            eBus[i] = act[4*i];
            eBrd[i] = act[28+4*i];
            xBus[i] = act[4*i+3 -: 3] == 3'h7 ? 1'b0 : eff[act[4*i+3 -: 3]];
            xBrd[i] = act[4*i+31 -: 3] == 3'h7 ? 1'b0 : busIn[act[4*i+31 -: 3]];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    a_oe_match: assert property ($stable(act) |->
        busOeN == ~eBus && boardOeN == ~eBrd) else $error("enables wrong");
    a_bus_route: assert property ($stable(act) && $stable(ctl) |->
        ((busOut ^ $past(xBus)) & eBus) == 7'h00) else $error("bus value");
    a_board_route: assert property ($stable(act) |->
        ((boardOut ^ $past(xBrd)) & eBrd) == 7'h00) else $error("board value");
    a_drive_sel: assert property ($stable(ctl) |->
        cnt2DriveN == !ctl[0] && cnt5DriveN == !ctl[2]) else $error("drive");
    a_gate_both: assert property ($stable(ctl) && ctl[1:0] == 2'h3 |->
        counter1_gate_input == $past(counter2_output)) else $error("gate");
    a_gate_recv: assert property ($stable(ctl) && ctl[1:0] == 2'h2 |->
        counter1_gate_input == $past(boardIn[2])) else $error("gate pin");
    a_dac_both: assert property ($stable(ctl) && ctl[3:2] == 2'h3 |->
        dac_update_trigger_n == $past(counter5_output)) else $error("dac");
    a_dac_off: assert property ($stable(ctl) && !ctl[3] |->
        dac_update_trigger_n) else $error("dac trigger not idle");
endmodule // trigger_bus_crosspoint_checker

// ==== testbench/trigger_line_partner.sv ====
// partner: other boards on the trigger lines, resolving each line level
`timescale 1ns/10ps
module trigger_line_partner (
    input wire logic mclk, // bus clock
    input wire logic [6:0] busOut, busOeN, // switch side of each line
    input wire logic [6:0] farVal, farEn, // far boards, enable high
    output logic [6:0] busIn // resolved line levels
);
    logic [6:0] last = 7'h00;
    // far boards drive only lines the switch leaves free
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!busOeN[i]) busIn[i] = busOut[i];
            else if (farEn[i]) busIn[i] = farVal[i];
            else busIn[i] = ~last[i];
        end
    end
    // a released line flips every cycle
    always @(posedge mclk) last <= busIn;
endmodule // trigger_line_partner
